// ===== core/rialc_bank.sv
// per-port alias config bank with address decode and remap
// ======================================================
// overview
// ======================================================
// Overview of operation
// - every register below exists per port and the port-select register picks the copy.
// - with the hold bit set, forward-channel loads of forward config are ignored.
// - the two-bit gpio count maps 00/01/10/11 to zero, one, two and four active gpios.
// - the gpio count loads from the link, and a local write lands only while hold is set.
// - the serializer address field is filled from link identity information.
// - with its hold bit set, the serializer address keeps the host-written value.
// - a local target address equal to the alias is forwarded with a remapped address.
// - an alias of zero disables the decoder.
// - with auto-ack set, local writes to the remote serializer are always acknowledged.
// - a remap slot of the selected port replaces the target address when its alias matches and no serializer alias does.
// - alias, auto-ack, remap slots and reserved fields reset to zero.
module rialc_bank
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output      logic [7:0]  reg_rdata_o,
   input  wire logic [3:0]  link_load_i,
   input  wire logic [1:0]  link_gpio_count_i [4],
   input  wire logic [6:0]  link_serializer_addr_i [4],
   input  wire logic [3:0]  link_locked_i,
   input  wire logic        fwd_req_i,
   input  wire logic [6:0]  fwd_target_i,
   input  wire logic        fwd_is_write_i,
   input  wire logic [1:0]  fwd_slot_alias_hit_i,
   output      logic        fwd_match_o,
   output      logic [1:0]  fwd_port_o,
   output      logic [6:0]  fwd_remap_addr_o,
   output      logic        fwd_local_ack_o,
   input  wire logic        remote_done_i,
   input  wire logic        remote_ack_i,
   input  wire logic [7:0]  remote_rdata_i,
   output      logic        host_stretch_o,
   output      logic        host_ack_o,
   output      logic        host_done_o,
   output      logic [7:0]  host_rdata_o,
   output      logic [2:0]  fwd_gpio_active_o [4]
);
   // ======================================================
   // state
   // ======================================================
   typedef enum logic [1:0] {IDLE, WAIT_REMOTE, REPLY} rialc_fsm_e;

   typedef struct packed {
      rialc_pkg::rialc_port_s [3:0] port;
      logic [7:0]                   port_sel;
      logic [7:0]                   rdata;
      rialc_fsm_e                   fsm;
      logic [1:0]                   fport;
      logic [6:0]                   remap;
      logic                         match;
      logic                         local_ack;
      logic                         ack;
      logic                         done;
      logic [7:0]                   hdata;
      logic [3:0][2:0]              gpio_act;
   } rialc_state_s;

   // reset image; every field named so a new field cannot slip past reset
   localparam rialc_pkg::rialc_port_s PORT_RST =
   '{
      local_config_hold:      1'b0,
      fwd_gpio_count:         rialc_pkg::GPIO_RESET,
      remote_serializer_addr: rialc_pkg::ADDR_RESET,
      hold_remote_addr:       1'b0,
      serializer_alias_addr:  rialc_pkg::ALIAS_OFF,
      remote_write_auto_ack:  1'b0,
      target_phys_addr_slot0: rialc_pkg::ADDR_RESET,
      target_phys_addr_slot1: rialc_pkg::ADDR_RESET
   };

   // whole-state reset image
   localparam rialc_state_s ST_RST =
   '{
      port:      {4{PORT_RST}},
      port_sel:  rialc_pkg::PORT_SEL_RESET,
      rdata:     rialc_pkg::REG_ZERO,
      fsm:       IDLE,
      fport:     2'h0,
      remap:     rialc_pkg::ADDR_RESET,
      match:     1'b0,
      local_ack: 1'b0,
      ack:       1'b0,
      done:      1'b0,
      hdata:     rialc_pkg::REG_ZERO,
      gpio_act:  {4{rialc_pkg::GPIO_ACT_0}}
   };

   rialc_state_s st;
   rialc_state_s next_st;
   logic [1:0]   sel;

   assign sel = st.port_sel[rialc_pkg::PORT_SEL_W-1:0];

   // ======================================================
   // next state
   // ======================================================
   always_comb
   begin
      logic       hit;
      logic [1:0] hport;
      logic [6:0] haddr;
      next_st = st;
      hit = 1'b0;
      hport = 2'h0;
      haddr = rialc_pkg::ADDR_RESET;
      // pulses last one cycle unless set again below
      next_st.done = 1'b0;
      next_st.local_ack = 1'b0;

      // link loading, per port
      for (int p = 0; p < rialc_pkg::NUM_PORTS; p++)
      begin
         if (link_load_i[p] && !st.port[p].local_config_hold)
            next_st.port[p].fwd_gpio_count = link_gpio_count_i[p];
         if (link_load_i[p] && !st.port[p].hold_remote_addr)
            next_st.port[p].remote_serializer_addr = link_serializer_addr_i[p];
      end

      // register writes; host wins over a same-cycle link load
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            rialc_pkg::PORT_SEL_OFFSET:
               next_st.port_sel = reg_wdata_i;
            rialc_pkg::FWD_CTL_OFFSET:
            begin
               next_st.port[sel].local_config_hold = reg_wdata_i[rialc_pkg::HOLD_BIT];
               if (st.port[sel].local_config_hold)
                  next_st.port[sel].fwd_gpio_count =
                     reg_wdata_i[rialc_pkg::GPIO_LSB +: 2];
            end
            rialc_pkg::SER_ADDR_OFFSET:
            begin
               next_st.port[sel].remote_serializer_addr =
                  reg_wdata_i[rialc_pkg::ADDR_LSB +: 7];
               next_st.port[sel].hold_remote_addr = reg_wdata_i[rialc_pkg::FLAG_BIT];
            end
            rialc_pkg::ALIAS_OFFSET:
            begin
               next_st.port[sel].serializer_alias_addr =
                  reg_wdata_i[rialc_pkg::ADDR_LSB +: 7];
               next_st.port[sel].remote_write_auto_ack = reg_wdata_i[rialc_pkg::FLAG_BIT];
            end
            rialc_pkg::REMAP0_OFFSET:
               next_st.port[sel].target_phys_addr_slot0 =
                  reg_wdata_i[rialc_pkg::ADDR_LSB +: 7];
            rialc_pkg::REMAP1_OFFSET:
               next_st.port[sel].target_phys_addr_slot1 =
                  reg_wdata_i[rialc_pkg::ADDR_LSB +: 7];
            default:
               next_st.port_sel = st.port_sel;
         endcase
      end

      // readback; reserved bits read zero
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            rialc_pkg::PORT_SEL_OFFSET:
               next_st.rdata = st.port_sel;
            rialc_pkg::FWD_CTL_OFFSET:
               next_st.rdata = {st.port[sel].local_config_hold, 5'h00,
                                st.port[sel].fwd_gpio_count};
            rialc_pkg::SER_ADDR_OFFSET:
               next_st.rdata = {st.port[sel].remote_serializer_addr,
                                st.port[sel].hold_remote_addr};
            rialc_pkg::ALIAS_OFFSET:
               next_st.rdata = {st.port[sel].serializer_alias_addr,
                                st.port[sel].remote_write_auto_ack};
            rialc_pkg::REMAP0_OFFSET:
               next_st.rdata = {st.port[sel].target_phys_addr_slot0, 1'b0};
            rialc_pkg::REMAP1_OFFSET:
               next_st.rdata = {st.port[sel].target_phys_addr_slot1, 1'b0};
            default:
               next_st.rdata = rialc_pkg::REG_ZERO;
         endcase
      end

      // gpio count decode
      // decoded from next state so the count and its decode move together
      for (int p = 0; p < rialc_pkg::NUM_PORTS; p++)
      begin
         unique case (next_st.port[p].fwd_gpio_count)
            rialc_pkg::GPIO_NONE: next_st.gpio_act[p] = rialc_pkg::GPIO_ACT_0;
            rialc_pkg::GPIO_ONE:  next_st.gpio_act[p] = rialc_pkg::GPIO_ACT_1;
            rialc_pkg::GPIO_TWO:  next_st.gpio_act[p] = rialc_pkg::GPIO_ACT_2;
            default:              next_st.gpio_act[p] = rialc_pkg::GPIO_ACT_4;
         endcase
      end

      // alias decode; overlapping aliases resolve to the lowest port
      for (int p = rialc_pkg::NUM_PORTS - 1; p >= 0; p--)
      begin
         if (st.port[p].serializer_alias_addr != rialc_pkg::ALIAS_OFF &&
             fwd_target_i == st.port[p].serializer_alias_addr)
         begin
            hit = 1'b1;
            hport = 2'(p);
            haddr = st.port[p].remote_serializer_addr;
         end
      end

      // slot remap
      // a serializer alias hit outranks a slot hit, so one request has one target
      if (!hit && fwd_slot_alias_hit_i[0])
      begin
         hit = 1'b1;
         hport = sel;
         haddr = st.port[sel].target_phys_addr_slot0;
      end
      else if (!hit && fwd_slot_alias_hit_i[1])
      begin
         hit = 1'b1;
         hport = sel;
         haddr = st.port[sel].target_phys_addr_slot1;
      end

      // forwarding sequence
      unique case (st.fsm)
         IDLE:
            if (fwd_req_i && hit)
            begin
               next_st.match = 1'b1;
               next_st.fport = hport;
               next_st.remap = haddr;
               if (fwd_is_write_i && st.port[hport].remote_write_auto_ack)
                  next_st.local_ack = 1'b1;
               next_st.fsm = WAIT_REMOTE;
            end
         WAIT_REMOTE:
            if (remote_done_i)
            begin
               // auto-ack also forces the relayed ack high
               next_st.ack = remote_ack_i || st.port[st.fport].remote_write_auto_ack;
               next_st.hdata = remote_rdata_i;
               next_st.done = 1'b1;
               next_st.match = 1'b0;
               next_st.fsm = REPLY;
            end
         REPLY:
            next_st.fsm = IDLE;
      endcase
   end

   // ======================================================
   // registers
   // ======================================================
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st <= ST_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ======================================================
   // outputs
   // ======================================================
   assign reg_rdata_o      = st.rdata;
   assign fwd_match_o      = st.match;
   assign fwd_port_o       = st.fport;
   assign fwd_remap_addr_o = st.remap;
   assign fwd_local_ack_o  = st.local_ack;
   // stretch holds the local bus until the remote answer arrives
   assign host_stretch_o   = (st.fsm == WAIT_REMOTE);
   assign host_ack_o       = st.ack;
   assign host_done_o      = st.done;
   assign host_rdata_o     = st.hdata;

   // per-port gpio count, already decoded in the state
   generate
      for (genvar g = 0; g < rialc_pkg::NUM_PORTS; g++)
      begin : gpio_out
         assign fwd_gpio_active_o[g] = st.gpio_act[g];
      end
   endgenerate

   // lock state is not needed: auto-ack ignores it
   logic unused_lock;
   assign unused_lock = |link_locked_i;
endmodule

// ===== core/rialc_pkg.sv
// package: offsets, field positions and reset values of the per-port alias config bank
package rialc_pkg;
   localparam int           NUM_PORTS        = 4;
   localparam int           PORT_SEL_W       = 2;
   localparam logic [7:0]   PORT_SEL_OFFSET  = 8'h4c;
   localparam logic [7:0]   FWD_CTL_OFFSET   = 8'h59;
   localparam logic [7:0]   FWD_SPARE_OFFSET = 8'h5a;
   localparam logic [7:0]   SER_ADDR_OFFSET  = 8'h5b;
   localparam logic [7:0]   ALIAS_OFFSET     = 8'h5c;
   localparam logic [7:0]   REMAP0_OFFSET    = 8'h5d;
   localparam logic [7:0]   REMAP1_OFFSET    = 8'h5e;
   localparam int           HOLD_BIT         = 7;
   localparam int           GPIO_LSB         = 0;
   localparam int           ADDR_LSB         = 1;
   localparam int           FLAG_BIT         = 0;
   localparam logic [1:0]   GPIO_RESET       = 2'h0;
   localparam logic [6:0]   ADDR_RESET       = 7'h00;
   localparam logic [7:0]   PORT_SEL_RESET   = 8'h00;
   localparam logic [7:0]   REG_ZERO         = 8'h00;
   localparam logic [6:0]   ALIAS_OFF        = 7'h00;
   // forward gpio count encodings
   localparam logic [1:0]   GPIO_NONE        = 2'h0;
   localparam logic [1:0]   GPIO_ONE         = 2'h1;
   localparam logic [1:0]   GPIO_TWO         = 2'h2;
   localparam logic [2:0]   GPIO_ACT_0       = 3'h0;
   localparam logic [2:0]   GPIO_ACT_1       = 3'h1;
   localparam logic [2:0]   GPIO_ACT_2       = 3'h2;
   localparam logic [2:0]   GPIO_ACT_4       = 3'h4;

   typedef struct packed {
      logic       local_config_hold;
      logic [1:0] fwd_gpio_count;
      logic [6:0] remote_serializer_addr;
      logic       hold_remote_addr;
      logic [6:0] serializer_alias_addr;
      logic       remote_write_auto_ack;
      logic [6:0] target_phys_addr_slot0;
      logic [6:0] target_phys_addr_slot1;
   } rialc_port_s;
endpackage

// ===== bench/rialc_bank_asserts.sv
// checker: port timing of the alias config bank
module rialc_bank_asserts
(
   input wire logic       sys_clk_i,
   input wire logic       rst_n_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       fwd_is_write_i,
   input wire logic       fwd_match_o,
   input wire logic [1:0] fwd_port_o,
   input wire logic [6:0] fwd_remap_addr_o,
   input wire logic       fwd_local_ack_o,
   input wire logic       remote_done_i,
   input wire logic [7:0] remote_rdata_i,
   input wire logic       host_stretch_o,
   input wire logic       host_done_o,
   input wire logic [7:0] host_rdata_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ===========
   // forward steps and register readback
   sequence s_answer;
      fwd_match_o && remote_done_i;
   endsequence
   sequence s_wait;
      fwd_match_o && !remote_done_i;
   endsequence
   done_after_answer_a: assert property (s_answer |=> host_done_o && !fwd_match_o)
      else $error("no done after remote answer");
   rdata_relay_a: assert property (s_answer |=> host_rdata_o == $past(remote_rdata_i))
      else $error("read data not relayed");
   done_cause_a: assert property (host_done_o |-> $past(fwd_match_o) && $past(remote_done_i))
      else $error("done without remote answer");
   busy_hold_a: assert property (s_wait |=> fwd_match_o && $stable(fwd_remap_addr_o) && $stable(fwd_port_o))
      else $error("forward target changed while busy");
   stretch_busy_a: assert property (fwd_match_o |-> host_stretch_o)
      else $error("host not stretched while forwarding");
   auto_ack_a: assert property (fwd_local_ack_o |-> $rose(fwd_match_o) && $past(fwd_is_write_i))
      else $error("local ack without new write");
   done_pulse_a: assert property (host_done_o |=> !host_done_o)
      else $error("done longer than one cycle");
   rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without read");
   spare_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h5a |=> reg_rdata_o == 8'h00)
      else $error("spare register not zero");
endmodule
bind rialc_bank rialc_bank_asserts u_chk (.*);

// ===== bench/rialc_remote_model.sv
// model: remote serializer answering forwarded transfers
module rialc_remote_model
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       fwd_match_i,
   input  wire logic [6:0] fwd_remap_addr_i,
   input  wire logic [3:0] delay_i,
   input  wire logic       nack_i,
   output      logic       remote_done_o,
   output      logic       remote_ack_o,
   output      logic [7:0] remote_rdata_o
);
   logic [3:0] cnt;
   // ===========
   // prompt or slow answer
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      remote_done_o <= 1'b0;
      // released data toggles so no stale value passes
      remote_rdata_o <= ~remote_rdata_o;
      if (!rst_n_i)
      begin
         cnt <= 4'h0;
         remote_ack_o <= 1'b0;
         remote_rdata_o <= 8'h00;
      end
      else if (fwd_match_i && !remote_done_o)
      begin
         cnt <= cnt + 4'h1;
         if (cnt == delay_i)
         begin
            remote_done_o <= 1'b1;
            remote_ack_o <= !nack_i;
            remote_rdata_o <= {1'b1, fwd_remap_addr_i};
            cnt <= 4'h0;
         end
      end
   end
endmodule

// ===== bench/remote_i2c_alias_config_tb.sv
// testbench: registers, link loads and forwarding of the alias config bank
module remote_i2c_alias_config_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_seen = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, remote_rdata_i, host_rdata_o;
   logic [7:0] al [4], sl [4];
   logic [3:0] link_load_i = 4'h0, link_locked_i = 4'h0, dly = 4'h0;
   logic [1:0] link_gpio_count_i [4] = '{default: 2'h0}, fwd_slot_alias_hit_i = 2'h0, fwd_port_o;
   logic [6:0] link_serializer_addr_i [4] = '{default: 7'h00}, fwd_target_i = 7'h00, fwd_remap_addr_o;
   logic fwd_req_i = 1'b0, fwd_is_write_i = 1'b0, nack = 1'b0, fwd_match_o, fwd_local_ack_o;
   logic remote_done_i, remote_ack_i, host_stretch_o, host_ack_o, host_done_o;
   logic [2:0] fwd_gpio_active_o [4];
   logic [8:0] exp_q [$];
   logic [31:0] lfsr = 32'h70a645df;
   int n_mismatch = 0, samples_checked = 0, cyc = 0, p, k;
   rialc_bank dut (.*);
   rialc_remote_model u_remote (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fwd_match_i(fwd_match_o),
      .fwd_remap_addr_i(fwd_remap_addr_o), .delay_i(dly), .nack_i(nack),
      .remote_done_o(remote_done_i), .remote_ack_o(remote_ack_i), .remote_rdata_o(remote_rdata_i));
   always #50 sys_clk_i = ~sys_clk_i;
   // ===========
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      // a note never answered is a lost result
      n_mismatch += exp_q.size();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // read notes its expected value; write when w is high
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= w;
      reg_rd_i <= !w;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      if (!w)
         exp_q.push_back({1'b0, d});
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
   endtask
   task automatic load(input logic [1:0] g, input logic [6:0] s);
      @(posedge sys_clk_i);
      link_gpio_count_i[3] <= g;
      link_serializer_addr_i[3] <= s;
      link_load_i <= 4'h8;
      @(posedge sys_clk_i);
      link_load_i <= 4'h0;
   endtask
   task automatic req(input logic [6:0] t, input logic [1:0] h, input logic w);
      @(posedge sys_clk_i);
      fwd_req_i <= 1'b1;
      fwd_target_i <= t;
      fwd_slot_alias_hit_i <= h;
      fwd_is_write_i <= w;
      @(posedge sys_clk_i);
      fwd_req_i <= 1'b0;
      @(negedge sys_clk_i);
   endtask
   task automatic fwd(input logic [6:0] t, input logic [1:0] h, input logic w, au, nk,
                      input logic [6:0] ra, input logic [3:0] lat);
      int i;
      lfsr = lfsr_next(lfsr);
      link_locked_i <= lfsr[3:0];
      nack <= nk;
      dly <= lat;
      exp_q.push_back({(au & w) | !nk, 1'b1, ra});
      req(t, h, w);
      check("remap", {2'h0, fwd_remap_addr_o}, {2'h0, ra});
      check("local_ack", {8'h00, fwd_local_ack_o}, {8'h00, au & w});
      check("port", {7'h00, fwd_port_o}, 9'h003);
      check("stretch", {8'h00, host_stretch_o}, 9'h001);
      for (i = 0; i < 40 && host_done_o !== 1'b1; i++)
         @(negedge sys_clk_i);
      check("done", {8'h00, host_done_o}, 9'h001);
      repeat (2) @(posedge sys_clk_i);
   endtask
   // ===========
   // monitor: oldest note against each answer
   always @(posedge sys_clk_i)
   begin
      rd_seen <= reg_rd_i;
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   always @(negedge sys_clk_i)
      if (rd_seen || host_done_o === 1'b1)
      begin
         // an answer with no note is a spurious result
         if (exp_q.size() == 0)
            n_mismatch++;
         else
            check("answer", rd_seen ? {1'b0, reg_rdata_o} : {host_ack_o, host_rdata_o},
                  exp_q.pop_front());
      end
   initial
   begin
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      for (p = 0; p < 4; p++)
      begin
         acc(1'b1, 8'h4c, p[7:0]);
         for (k = 0; k < 4; k++)
            acc(1'b0, k == 0 ? 8'h5a : 8'h5b + k[7:0], 8'h00);
         lfsr = lfsr_next(lfsr);
         // port number in the low alias bits keeps the four aliases distinct
         al[p] = {lfsr[6:2] | 5'h01, p[1:0], 1'b0};
         sl[p] = {lfsr[14:8], 1'b0};
         acc(1'b1, 8'h5c, al[p]);
         // reserved bit written high must read low
         acc(1'b1, 8'h5d, sl[p] | 8'h01);
      end
      for (p = 0; p < 4; p++)
      begin
         acc(1'b1, 8'h4c, p[7:0]);
         acc(1'b0, 8'h5c, al[p]);
         acc(1'b0, 8'h5d, sl[p]);
      end
      $display("test port copies done");
      acc(1'b1, 8'h59, 8'h03);
      acc(1'b0, 8'h59, 8'h00);
      for (k = 0; k < 4; k++)
      begin
         acc(1'b1, 8'h59, 8'h80 | k[7:0]);
         acc(1'b0, 8'h59, 8'h80 | k[7:0]);
         check("gpio_active", {6'h00, fwd_gpio_active_o[3]}, k == 3 ? 9'h004 : k[8:0]);
      end
      load(2'h1, 7'h35);
      acc(1'b0, 8'h59, 8'h83);
      acc(1'b1, 8'h59, 8'h00);
      load(2'h2, 7'h35);
      acc(1'b0, 8'h59, 8'h02);
      acc(1'b0, 8'h5b, 8'h6a);
      acc(1'b1, 8'h5b, 8'h23);
      load(2'h1, 7'h22);
      acc(1'b0, 8'h5b, 8'h23);
      acc(1'b0, 8'h59, 8'h01);
      $display("test link loads done");
      fwd(al[3][7:1], 2'h0, 1'b0, 1'b0, 1'b0, 7'h11, 4'h0);
      fwd(al[3][7:1], 2'h0, 1'b1, 1'b0, 1'b1, 7'h11, 4'h9);
      fwd(7'h50, 2'h1, 1'b0, 1'b0, 1'b0, sl[3][7:1], 4'h3);
      acc(1'b1, 8'h5c, al[3] | 8'h01);
      fwd(al[3][7:1], 2'h0, 1'b1, 1'b1, 1'b1, 7'h11, 4'h5);
      acc(1'b1, 8'h5c, 8'h00);
      req(7'h00, 2'h0, 1'b1);
      repeat (3) @(negedge sys_clk_i);
      check("alias_off", {8'h00, fwd_match_o}, 9'h000);
      $display("test forwarding done");
      tally_and_finish();
   end
endmodule
